// ---- core/sas_cfg.svh ----
`ifndef SAS_CFG_SVH
`define SAS_CFG_SVH

// ===========================================================
// Register byte offsets (low address byte)
`define SAS_OFF_CTRL      8'h00
`define SAS_OFF_SEQ       8'h04
`define SAS_OFF_TIME      8'h08
`define SAS_OFF_INSEL     8'h0C
`define SAS_OFF_SCAN      8'h10
`define SAS_OFF_BUF       8'h40
`define SAS_OFF_BUF_END   8'h7C

// ===========================================================
// Control register fields
`define SAS_CTRL_ON       15
`define SAS_CTRL_FORM     8
`define SAS_CTRL_TRIG     5
`define SAS_CTRL_IFLAG    4
`define SAS_CTRL_SIMUL    3
`define SAS_CTRL_AUTO     2
`define SAS_CTRL_SAMPLE_START_BIT     1
`define SAS_CTRL_DONE     0

// ===========================================================
// Sequence register fields
`define SAS_SEQ_SCAN      10
`define SAS_SEQ_CHCNT     8
`define SAS_SEQ_HALF      7
`define SAS_SEQ_SPI       2
`define SAS_SEQ_SPLIT     1
`define SAS_SEQ_ALT       0

// ===========================================================
// Timing and input select fields
`define SAS_TIME_AUTO_SAMPLE_CLOCKS     8
`define SAS_TIME_DIV      0
`define SAS_INSEL_A       0
`define SAS_INSEL_B       8

// ===========================================================
// Reset values
`define SAS_RST_CTRL      16'h0000
`define SAS_RST_SEQ       16'h0000
`define SAS_RST_TIME      16'h0000
`define SAS_RST_INSEL     16'h0000
`define SAS_RST_SCAN      16'h0000
`define SAS_RST_RESULT    10'h000

// ===========================================================
// Trigger source codes and timing counts
`define SAS_TRIG_SW       3'h0
`define SAS_TRIG_EXT      3'h1
`define SAS_TRIG_TIMER    3'h2
`define SAS_TRIG_AUTO     3'h7
`define SAS_CONV_TAD      5'h0C

`endif

// ---- core/sas_pkg.sv ----
package sas_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SAMPLE,
        SEQ_CONVERT
    } sas_state_e;

    typedef enum logic [1:0] {
        FORM_UINT,
        FORM_SINT,
        FORM_UFRAC,
        FORM_SFRAC
    } sas_form_e;

    typedef logic [9:0]  sas_result_t;
    typedef logic [15:0] sas_word_t;
endpackage

// ---- core/sas_result_buf.sv ----
`timescale 1ns/1ps
`include "sas_cfg.svh"

module sas_result_buf (
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    input  wire logic                 wr_en_i,
    input  wire logic [3:0]           wr_addr_i,
    input  wire sas_pkg::sas_result_t wr_data_i,
    input  wire logic [3:0]           rd_addr_i,
    input  wire logic [1:0]           form_i,
    output sas_pkg::sas_word_t        rd_data_o
);

    sas_pkg::sas_result_t mem_q [16];

    // ===========================================================
    // Formatting of a 10-bit result into a 16-bit word
    function automatic sas_pkg::sas_word_t fmt(
        input sas_pkg::sas_result_t d,
        input logic [1:0]           f
    );
        case (sas_pkg::sas_form_e'(f))
            sas_pkg::FORM_UINT:  fmt = {6'h00, d};
            sas_pkg::FORM_SINT:  fmt = {{7{~d[9]}}, d[8:0]};
            sas_pkg::FORM_UFRAC: fmt = {d, 6'h00};
            sas_pkg::FORM_SFRAC: fmt = {~d[9], d[8:0], 6'h00};
            default:             fmt = {6'h00, d};
        endcase
    endfunction

    // ===========================================================
    // Write port belongs to the sequencer only; software reads
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= `SAS_RST_RESULT;
            end
        end else if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    always_comb begin
        rd_data_o = fmt(mem_q[rd_addr_i], form_i);
    end

endmodule

// ---- core/sas_top.sv ----
// Functional notes
// - Ten-bit results; sixteen inputs muxed to four sample-holds, one ADC.
// - Sixteen-word result buffer, software may read it but never write it.
// - Entries hold 10 bits, read as 16-bit words in selectable format.
// - Setting the sample start bit begins acquisition on selected channels.
// - A trigger ends acquisition and starts conversion.
// - Each result is buffered; flags set after programmed sequence count.
// - Sequential mode acquires and converts channels one after another.
// - Simultaneous mode acquires channels together, converts them in turn.
// - Channel count selects channel 0, channels 0-1, or channels 0-3.
// - Sequence field at bits 5:2 sets 1 to 16 sequences per interrupt.
// - Split mode uses two 8-word halves, swapping after each interrupt.
// - Split with sequence field 0111 fills one half, then the other.
// - Alternate bit clear samples only multiplexer set A.
// - Alternate bit set alternates set A and set B per sequence.
// - Scan enable at bit 10 steps channel 0 through selected inputs.
// - Scan ascends, restarts after interrupt; surplus inputs skipped.
// - Sequencing keeps running while the rest of the device sleeps.
// - Trigger source 000 converts when software clears the sample bit.
// - Source 111 converts after the programmed sample clocks, at least one.
// - Each conversion takes twelve converter clock periods.
`timescale 1ns/1ps
`include "sas_cfg.svh"

module sas_top (
    input  wire logic        CLOCK_I,
    input  wire logic        RSTN_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    input  wire logic [9:0]  ADC_RESULT_I,
    input  wire logic        EXT_TRIG_I,
    input  wire logic        TIMER_TRIG_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    output logic      [3:0]  SH_SAMPLE_O,
    output logic      [3:0]  MUX_CH0_SEL_O,
    output logic             MUX_SET_B_O,
    output logic             CONV_ACTIVE_O,
    output logic      [1:0]  CONV_CH_O,
    output logic             IRQ_FLAG_O,
    output logic             DONE_O
);

    // ===========================================================
    // Pin synchronisers
    logic [9:0] res_s1_q, res_s2_q;
    logic       ext_s1_q, ext_s2_q, ext_s3_q;

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            res_s1_q <= 10'h000;
            res_s2_q <= 10'h000;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            res_s1_q <= ADC_RESULT_I;
            res_s2_q <= res_s1_q;
            ext_s1_q <= EXT_TRIG_I;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // ===========================================================
    // AHB-Lite slave: writes are zero wait, reads take one wait state
    logic        wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
    logic [7:0]  addr_q, addr_d;
    logic        hready_q, hready_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic        take;
    logic        bus_wr;
    logic [15:0] wdata;
    sas_pkg::sas_word_t buf_word;

    assign take   = HSEL_I && HTRANS_I[1] && HREADY_I && HSIZE_I == 3'h2;
    assign bus_wr = wr_pend_q;
    assign wdata  = HWDATA_I[15:0];

    // ===========================================================
    // Control state
    logic [15:0] ctrl_q, ctrl_d, seq_q, seq_d, time_q, time_d;
    logic [15:0] insel_q, insel_d, scan_q, scan_d;
    sas_pkg::sas_state_e st_q, st_d;
    logic [5:0]  tad_q, tad_d;
    logic [4:0]  ph_q, ph_d;
    logic [1:0]  ch_q, ch_d;
    logic [3:0]  seqn_q, seqn_d, wptr_q, wptr_d, spos_q, spos_d;
    logic        half_q, half_d, altb_q, altb_d;
    logic [3:0]  sh_q, sh_d, ch0sel_q, ch0sel_d;
    logic        conv_q, conv_d;
    logic        we;
    logic        tad_tick, trig, last_ch;
    logic [2:0]  nch;
    logic [4:0]  auto_sample_clocks, scan_hit;

    function automatic logic [15:0] rd_reg(input logic [7:0] a,
                                           input logic [15:0] c,
                                           input logic [15:0] s,
                                           input logic [15:0] t,
                                           input logic [15:0] i,
                                           input logic [15:0] n);
        case (a)
            `SAS_OFF_CTRL:  rd_reg = c;
            `SAS_OFF_SEQ:   rd_reg = s;
            `SAS_OFF_TIME:  rd_reg = t;
            `SAS_OFF_INSEL: rd_reg = i;
            `SAS_OFF_SCAN:  rd_reg = n;
            default:        rd_reg = 16'h0000;
        endcase
    endfunction

    // First selected input at or above pos, wrapping; bit 4 flags a hit
    function automatic logic [4:0] next_scan(input logic [15:0] sel,
                                             input logic [3:0]  pos);
        logic [4:0] hit;
        hit = 5'h00;
        for (int k = 15; k >= 0; k--) begin
            if (sel[k]) begin
                hit = {1'b1, 4'(k)};
            end
        end
        for (int k = 15; k >= 0; k--) begin
            if (sel[k] && 4'(k) >= pos) begin
                hit = {1'b1, 4'(k)};
            end
        end
        next_scan = hit;
    endfunction

    always_comb begin
        wr_pend_d = take && HWRITE_I;
        rd_pend_d = take && !HWRITE_I;
        addr_d    = take ? HADDR_I[7:0] : addr_q;
        hready_d  = !(take && !HWRITE_I);
        hrdata_d  = hrdata_q;
        if (rd_pend_q) begin
            if (addr_q >= `SAS_OFF_BUF && addr_q <= `SAS_OFF_BUF_END
                && addr_q[1:0] == 2'h0) begin
                hrdata_d = {16'h0000, buf_word};
            end else begin
                hrdata_d = {16'h0000,
                            rd_reg(addr_q, ctrl_q, seq_q, time_q,
                                   insel_q, scan_q)};
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            hready_q  <= 1'b1;
            hrdata_q  <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            addr_q    <= addr_d;
            hready_q  <= hready_d;
            hrdata_q  <= hrdata_d;
        end
    end

    // ===========================================================
    // Result buffer
    sas_result_buf u_buf (
        .clk_i     (CLOCK_I),
        .rstn_i    (RSTN_I),
        .wr_en_i   (we),
        .wr_addr_i (wptr_q),
        .wr_data_i (res_s2_q),
        .rd_addr_i (addr_q[5:2]),
        .form_i    (ctrl_q[`SAS_CTRL_FORM +: 2]),
        .rd_data_o (buf_word)
    );

    // ===========================================================
    // Registers and sequencer. No sleep input: it keeps running
    // whatever the core does.
    always_comb begin
        ctrl_d   = ctrl_q;
        seq_d    = seq_q;
        time_d   = time_q;
        insel_d  = insel_q;
        scan_d   = scan_q;
        st_d     = st_q;
        tad_d    = tad_q;
        ph_d     = ph_q;
        ch_d     = ch_q;
        seqn_d   = seqn_q;
        wptr_d   = wptr_q;
        spos_d   = spos_q;
        half_d   = half_q;
        altb_d   = altb_q;
        sh_d     = sh_q;
        ch0sel_d = ch0sel_q;
        conv_d   = conv_q;
        we       = 1'b0;
        trig     = 1'b0;
        // Half status bit is read-only; fields are stored as written
        if (bus_wr) begin
            case (addr_q)
                `SAS_OFF_CTRL:  ctrl_d  = wdata;
                `SAS_OFF_SEQ:   seq_d   = {wdata[15:8], seq_q[7],
                                           wdata[6:0]};
                `SAS_OFF_TIME:  time_d  = wdata;
                `SAS_OFF_INSEL: insel_d = wdata;
                `SAS_OFF_SCAN:  scan_d  = wdata;
                default:        ;
            endcase
        end
        case (seq_q[`SAS_SEQ_CHCNT +: 2])
            2'h0:    nch = 3'h1;
            2'h1:    nch = 3'h2;
            default: nch = 3'h4;
        endcase
        last_ch  = 3'({1'b0, ch_q}) + 3'h1 >= nch;
        auto_sample_clocks     = time_q[`SAS_TIME_AUTO_SAMPLE_CLOCKS +: 5];
        scan_hit = next_scan(scan_q, spos_q);
        tad_tick = tad_q == time_q[`SAS_TIME_DIV +: 6];
        tad_d    = (st_q == sas_pkg::SEQ_IDLE || tad_tick)
                   ? 6'h00 : tad_q + 6'h01;
        case (st_q)
            sas_pkg::SEQ_IDLE: begin
                if (ctrl_d[`SAS_CTRL_ON] && ctrl_d[`SAS_CTRL_SAMPLE_START_BIT]) begin
                    st_d = sas_pkg::SEQ_SAMPLE;
                    ch_d = 2'h0;
                    ph_d = 5'h00;
                    sh_d = ctrl_d[`SAS_CTRL_SIMUL]
                           ? 4'((5'h01 << nch) - 5'h01) : 4'h1;
                    if (seq_q[`SAS_SEQ_SCAN] && scan_hit[4]) begin
                        ch0sel_d = scan_hit[3:0];
                    end else if (seq_q[`SAS_SEQ_ALT] && altb_q) begin
                        ch0sel_d = insel_q[`SAS_INSEL_B +: 4];
                    end else begin
                        ch0sel_d = insel_q[`SAS_INSEL_A +: 4];
                    end
                end
            end
            sas_pkg::SEQ_SAMPLE: begin
                if (tad_tick && ph_q != 5'h1F) begin
                    ph_d = ph_q + 5'h01;
                end
                case (ctrl_q[`SAS_CTRL_TRIG +: 3])
                    `SAS_TRIG_SW:    trig = !ctrl_d[`SAS_CTRL_SAMPLE_START_BIT];
                    `SAS_TRIG_EXT:   trig = ext_s2_q && !ext_s3_q;
                    `SAS_TRIG_TIMER: trig = TIMER_TRIG_I;
                    `SAS_TRIG_AUTO:  trig = tad_tick &&
                        (ph_q + 5'h01 >= auto_sample_clocks);
                    default:         trig = 1'b0;
                endcase
                if (trig) begin
                    st_d   = sas_pkg::SEQ_CONVERT;
                    ctrl_d[`SAS_CTRL_SAMPLE_START_BIT] = 1'b0;
                    sh_d   = 4'h0;
                    ph_d   = 5'h00;
                    conv_d = 1'b1;
                end
            end
            sas_pkg::SEQ_CONVERT: begin
                if (tad_tick) begin
                    ph_d = ph_q + 5'h01;
                end
                if (tad_tick && ph_q == `SAS_CONV_TAD - 5'h01) begin
                    we     = 1'b1;
                    wptr_d = wptr_q + 4'h1;
                    ph_d   = 5'h00;
                    if (!last_ch) begin
                        ch_d = ch_q + 2'h1;
                        if (!ctrl_q[`SAS_CTRL_SIMUL]) begin
                            // Next channel gets its own sample clock
                            st_d   = sas_pkg::SEQ_SAMPLE;
                            conv_d = 1'b0;
                            sh_d   = 4'(5'h01 << (ch_q + 2'h1));
                            ctrl_d[`SAS_CTRL_SAMPLE_START_BIT] = 1'b1;
                        end
                    end else begin
                        ch_d   = 2'h0;
                        conv_d = 1'b0;
                        altb_d = seq_q[`SAS_SEQ_ALT] && !altb_q;
                        if (seq_q[`SAS_SEQ_SCAN] && scan_hit[4]) begin
                            spos_d = scan_hit[3:0] + 4'h1;
                        end
                        seqn_d = seqn_q + 4'h1;
                        if (seqn_q == seq_q[`SAS_SEQ_SPI +: 4]) begin
                            // Flag sets win over a same-cycle clear
                            ctrl_d[`SAS_CTRL_IFLAG] = 1'b1;
                            ctrl_d[`SAS_CTRL_DONE]  = 1'b1;
                            seqn_d = 4'h0;
                            spos_d = 4'h0;
                            if (seq_q[`SAS_SEQ_SPLIT]) begin
                                half_d = !half_q;
                                wptr_d = {!half_q, 3'h0};
                            end else begin
                                wptr_d = 4'h0;
                            end
                        end
                        if (ctrl_q[`SAS_CTRL_AUTO]) begin
                            ctrl_d[`SAS_CTRL_SAMPLE_START_BIT] = 1'b1;
                        end
                        st_d = sas_pkg::SEQ_IDLE;
                    end
                end
            end
            default: st_d = sas_pkg::SEQ_IDLE;
        endcase
        seq_d[`SAS_SEQ_HALF] = half_d;
        // Turning the converter off aborts and keeps the last results
        if (!ctrl_d[`SAS_CTRL_ON]) begin
            st_d   = sas_pkg::SEQ_IDLE;
            ch_d   = 2'h0;
            ph_d   = 5'h00;
            seqn_d = 4'h0;
            spos_d = 4'h0;
            half_d = 1'b0;
            altb_d = 1'b0;
            wptr_d = 4'h0;
            sh_d   = 4'h0;
            conv_d = 1'b0;
            seq_d[`SAS_SEQ_HALF] = 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            ctrl_q   <= `SAS_RST_CTRL;
            seq_q    <= `SAS_RST_SEQ;
            time_q   <= `SAS_RST_TIME;
            insel_q  <= `SAS_RST_INSEL;
            scan_q   <= `SAS_RST_SCAN;
            st_q     <= sas_pkg::SEQ_IDLE;
            tad_q    <= 6'h00;
            ph_q     <= 5'h00;
            ch_q     <= 2'h0;
            seqn_q   <= 4'h0;
            wptr_q   <= 4'h0;
            spos_q   <= 4'h0;
            half_q   <= 1'b0;
            altb_q   <= 1'b0;
            sh_q     <= 4'h0;
            ch0sel_q <= 4'h0;
            conv_q   <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            seq_q    <= seq_d;
            time_q   <= time_d;
            insel_q  <= insel_d;
            scan_q   <= scan_d;
            st_q     <= st_d;
            tad_q    <= tad_d;
            ph_q     <= ph_d;
            ch_q     <= ch_d;
            seqn_q   <= seqn_d;
            wptr_q   <= wptr_d;
            spos_q   <= spos_d;
            half_q   <= half_d;
            altb_q   <= altb_d;
            sh_q     <= sh_d;
            ch0sel_q <= ch0sel_d;
            conv_q   <= conv_d;
        end
    end

    // ===========================================================
    // Outputs straight from flip-flops, except HRESP_O tied low
    assign HRDATA_O      = hrdata_q;
    assign HREADYOUT_O   = hready_q;
    assign HRESP_O       = 1'b0;
    assign SH_SAMPLE_O   = sh_q;
    assign MUX_CH0_SEL_O = ch0sel_q;
    assign MUX_SET_B_O   = altb_q;
    assign CONV_ACTIVE_O = conv_q;
    assign CONV_CH_O     = ch_q;
    assign IRQ_FLAG_O    = ctrl_q[`SAS_CTRL_IFLAG];
    assign DONE_O        = ctrl_q[`SAS_CTRL_DONE];

endmodule

// ---- test/sas_top_checker.sv ----
`timescale 1ns/1ps
module sas_top_checker (
    input  wire logic        CLOCK_I,
    input  wire logic        RSTN_I,
    input  wire logic        HSEL_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic        HREADY_I,
    input  wire logic [31:0] HRDATA_O,
    input  wire logic        HREADYOUT_O,
    input  wire logic        HRESP_O,
    input  wire logic [3:0]  SH_SAMPLE_O,
    input  wire logic        CONV_ACTIVE_O,
    input  wire logic        IRQ_FLAG_O,
    input  wire logic        DONE_O
);
    // ===========================================================
    // Bus phase decode
    logic taken;
    assign taken = HSEL_I && HTRANS_I[1] && HREADY_I && (HSIZE_I == 3'h2);

    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RSTN_I);

    sequence read_answer;
        !HREADYOUT_O ##1 HREADYOUT_O;
    endsequence
    // A conversion may run longer with a slow divider, never shorter
    sequence conv_hold;
        CONV_ACTIVE_O[*8] ##1 CONV_ACTIVE_O[*4];
    endsequence

    // ===========================================================
    // Properties
    a_resp_okay: assert property (HRESP_O == 1'b0)
        else $error("bus response not OKAY");
    a_read_wait: assert property (taken && !HWRITE_I |=> read_answer)
        else $error("read wait state wrong");
    a_write_nowait: assert property (
        taken && HWRITE_I |=> HREADYOUT_O)
        else $error("write stalled the bus");
    a_upper_zero: assert property (HRDATA_O[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_reset_idle: assert property ($rose(RSTN_I) |-> SH_SAMPLE_O == 4'h0
        && !CONV_ACTIVE_O && !IRQ_FLAG_O && !DONE_O)
        else $error("outputs busy after reset");
    a_conv_length: assert property ($rose(CONV_ACTIVE_O) |-> conv_hold)
        else $error("conversion shorter than twelve clocks");
    a_conv_nosample: assert property (CONV_ACTIVE_O |-> SH_SAMPLE_O == 4'h0)
        else $error("sampling while converting");
    a_flags_pair: assert property ($rose(IRQ_FLAG_O) |-> DONE_O)
        else $error("interrupt flag without done");
endmodule

// ---- test/test_sas_top.sv ----
`timescale 1ns/1ps
module test_sas_top;
    logic        CLOCK_I      = 1'b0;
    logic        RSTN_I       = 1'b0;
    logic        HSEL_I       = 1'b0;
    logic [31:0] HADDR_I      = 32'h0;
    logic [1:0]  HTRANS_I     = 2'h0;
    logic        HWRITE_I     = 1'b0;
    logic [31:0] HWDATA_I     = 32'h0;
    logic [9:0]  ADC_RESULT_I = 10'h000;
    logic        EXT_TRIG_I   = 1'b0;
    logic        TIMER_TRIG_I = 1'b0;
    logic [31:0] HRDATA_O;
    logic        HREADYOUT_O, HRESP_O, MUX_SET_B_O, CONV_ACTIVE_O;
    logic [3:0]  SH_SAMPLE_O, MUX_CH0_SEL_O;
    logic [1:0]  CONV_CH_O;
    logic        IRQ_FLAG_O, DONE_O;
    int          err_count = 0, n_compared = 0, seed = 74, cycles = 0;
    logic [31:0] rd;
    logic [9:0]  r;
    logic [1:0]  top_ch;
    logic        sim;
    logic [2:0]  srcs [4] = '{3'h0, 3'h1, 3'h2, 3'h7};

    always #5 CLOCK_I = ~CLOCK_I;

    sas_top i_sas_top (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I),
        .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
        .HSIZE_I(3'h2), .HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O),
        .ADC_RESULT_I(ADC_RESULT_I), .EXT_TRIG_I(EXT_TRIG_I),
        .TIMER_TRIG_I(TIMER_TRIG_I), .HRDATA_O(HRDATA_O),
        .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
        .SH_SAMPLE_O(SH_SAMPLE_O), .MUX_CH0_SEL_O(MUX_CH0_SEL_O),
        .MUX_SET_B_O(MUX_SET_B_O), .CONV_ACTIVE_O(CONV_ACTIVE_O),
        .CONV_CH_O(CONV_CH_O), .IRQ_FLAG_O(IRQ_FLAG_O), .DONE_O(DONE_O));

    // ===========================================================
    // Helpers
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen,
               input logic [31:0] ex);
        n_compared++;
        if (seen !== ex) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    // Single AHB transfer; entered just after a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        HSEL_I   <= 1'b1;
        HTRANS_I <= 2'h2;
        HWRITE_I <= w;
        HADDR_I  <= {24'h0, a};
        do @(posedge CLOCK_I); while (HREADYOUT_O !== 1'b1);
        HSEL_I   <= 1'b0;
        HTRANS_I <= 2'h0;
        HWDATA_I <= wd;
        do @(posedge CLOCK_I); while (HREADYOUT_O !== 1'b1);
        rd = HRDATA_O;
    endtask

    function automatic logic [31:0] fmt_uint(input logic [9:0] v);
        return {22'h0, v};
    endfunction

    // Signed forms are offset by half scale; fractions are left-justified
    function automatic logic [31:0] fmt_any(input logic [9:0] v, input int f);
        int s;
        s = f % 2 == 1 ? int'(v) - 512 : int'(v);
        return {16'h0, 16'(f >= 2 ? s * 64 : s)};
    endfunction

    task wait_irq;
        top_ch = 2'h0;
        while (IRQ_FLAG_O !== 1'b1) begin
            @(posedge CLOCK_I);
            if (CONV_ACTIVE_O === 1'b1 && CONV_CH_O > top_ch) begin
                top_ch = CONV_CH_O;
            end
        end
    endtask

    // Hang guard: the whole sequence needs about 1000 cycles
    always @(posedge CLOCK_I) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("MISMATCH run time expected end seen hang");
            finish_test();
        end
    end

    // ===========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge CLOCK_I);
        RSTN_I <= 1'b1;
        @(posedge CLOCK_I);
        for (int a = 0; a <= 'h44; a += 4) begin
            bus(1'b0, 8'(a), 32'h0);
            check("reset or unmapped word", rd, 32'h0);
        end
        bus(1'b1, 8'h40, $random(seed));
        bus(1'b0, 8'h40, 32'h0);
        check("buffer after write", rd, 32'h0);
        $display("test reset and read only done");

        bus(1'b1, 8'h08, 32'h0000_0100);
        for (int i = 0; i < 4; i++) begin
            r = 10'($random(seed));
            ADC_RESULT_I <= r;
            bus(1'b1, 8'h00, 32'h8002 | (32'(srcs[i]) << 5));
            repeat (4) @(posedge CLOCK_I);
            case (srcs[i])
                3'h0: bus(1'b1, 8'h00, 32'h8000);
                3'h1: begin
                    EXT_TRIG_I <= 1'b1;
                    repeat (2) @(posedge CLOCK_I);
                    EXT_TRIG_I <= 1'b0;
                end
                3'h2: begin
                    TIMER_TRIG_I <= 1'b1;
                    @(posedge CLOCK_I);
                    TIMER_TRIG_I <= 1'b0;
                end
                default: ;
            endcase
            wait_irq();
            bus(1'b0, 8'h40, 32'h0);
            check("triggered result", rd, fmt_uint(r));
            bus(1'b1, 8'h00, 32'h0);
        end
        $display("test trigger sources done");

        // Long sampling leaves room to switch off before the next conversion
        bus(1'b1, 8'h08, 32'h0000_1400);
        for (int c = 0; c < 3; c++) begin
            r = 10'($random(seed));
            ADC_RESULT_I <= r;
            bus(1'b1, 8'h04, (32'(c) << 8) | (32'(c == 0 ? 3 : c == 1) << 2));
            sim = 1'($random(seed));
            bus(1'b1, 8'h00, 32'h80E6 | (32'(sim) << 3));
            @(posedge CLOCK_I);
            check("hold mask", 32'(SH_SAMPLE_O),
                  sim ? (1 << (1 << c)) - 1 : 1);
            wait_irq();
            check("last channel", 32'(top_ch), (1 << c) - 1);
            bus(1'b1, 8'h00, 32'h0);
            for (int w = 0; w < 4; w++) begin
                bus(1'b0, 8'(8'h40 + 4 * w), 32'h0);
                check("channel result", rd, fmt_uint(r));
            end
            bus(1'b0, 8'h50, 32'h0);
            check("word past count", rd, 32'h0);
        end
        $display("test channel counts done");

        r = 10'($random(seed));
        ADC_RESULT_I <= r;
        bus(1'b1, 8'h04, 32'h0000_001E);
        bus(1'b1, 8'h00, 32'h80E6);
        wait_irq();
        bus(1'b0, 8'h04, 32'h0);
        check("half in use", {31'h0, rd[7]}, 32'h1);
        bus(1'b1, 8'h00, 32'h0);
        for (int w = 0; w < 9; w++) begin
            bus(1'b0, 8'(8'h40 + 4 * w), 32'h0);
            check("split half", rd, w < 8 ? fmt_uint(r) : 32'h0);
        end
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, 8'h00, 32'(f) << 8);
            bus(1'b0, 8'h40, 32'h0);
            check("result format", rd, fmt_any(r, f));
        end
        $display("test split buffer done");

        // Scan restarts low after each interrupt; set B follows set A
        bus(1'b1, 8'h0C, 32'h0000_0A05);
        bus(1'b1, 8'h10, 32'h0000_0140);
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, 8'h04, m ? 32'h0000_0001 : 32'h0000_0404);
            bus(1'b1, 8'h00, 32'h80E6);
            @(posedge CLOCK_I);
            check("first in", 32'(MUX_CH0_SEL_O), m ? 5 : 6);
            wait_irq();
            check("set b", 32'(MUX_SET_B_O), 32'(m));
            check("last in", 32'(MUX_CH0_SEL_O), m ? 5 : 8);
            @(posedge CLOCK_I);
            check("next in", 32'(MUX_CH0_SEL_O), m ? 'hA : 6);
            bus(1'b1, 8'h00, 32'h0);
        end
        $display("test scan and alternate done");
        finish_test();
    end
endmodule

bind sas_top sas_top_checker i_sas_top_checker (.CLOCK_I(CLOCK_I),
    .RSTN_I(RSTN_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .SH_SAMPLE_O(SH_SAMPLE_O), .CONV_ACTIVE_O(CONV_ACTIVE_O),
    .IRQ_FLAG_O(IRQ_FLAG_O), .DONE_O(DONE_O));
